/* File: rtl/cdd_defines.svh */
// Register map, field positions and reset values of the cascaded divider
// Function
// [R1] Software sets low count equal to high count for an even stage.
// [R2] Software sets low count one above high count for an odd stage.
// [R3] With one stage bypassed, software bypasses the second and keeps the first.
// [R4] With one even stage only, software puts it on the second stage.
// [R5] Uncorrected upstream divider alone gives 50%, 33.3% or 40% high time.
// [R6] Uncorrected, no upstream divider, both stages bypassed: input duty passes unchanged.
// [R7] Uncorrected active stage: high fraction is (N+1)/(N+M+2) of last stage.
// [R8] Corrected, 50% source, balanced counts: output is always 50%.
// [R9] Corrected, any source: even upstream or balanced even stage gives 50%.
// [R10] Corrected, both bypassed: (1+X)/3 for ratio three, (2+X)/5 for five.
// [R11] Correction is on after reset until the disable bit is set.
// [R12] Each count field holds cycles minus one.
// [R13] Both stages active: total division is the product of the stage ratios.
`ifndef CDD_DEFINES_SVH
`define CDD_DEFINES_SVH
`define CDD_ADDR_STAGE1   4'h0
`define CDD_ADDR_STAGE2   4'h1
`define CDD_ADDR_CTRL     4'h2
`define CDD_ADDR_STATUS   4'h3
`define CDD_HIGH_MSB      3
`define CDD_HIGH_LSB      0
`define CDD_LOW_MSB       7
`define CDD_LOW_LSB       4
`define CDD_CTRL_DCC_DIS  0
`define CDD_CTRL_BYP1     4
`define CDD_CTRL_BYP2     5
`define CDD_CTRL_PRE_MSB  7
`define CDD_CTRL_PRE_LSB  6
`define CDD_STAT_CLK      0
`define CDD_STAT_BYP_MIS  1
`define CDD_STAT_UNBAL    2
`define CDD_STAT_EVEN_MIS 3
`define CDD_STAGE_RESET   8'h00
`define CDD_CTRL_RESET    8'h30
`define CDD_CNT_START     5'h1f
`define CDD_PRE2_HIGH     4'h0
`define CDD_PRE2_LOW      4'h0
`define CDD_PRE3_HIGH     4'h0
`define CDD_PRE3_LOW      4'h1
`define CDD_PRE5_HIGH     4'h1
`define CDD_PRE5_LOW      4'h2
`endif

/* File: rtl/cdd_pkg.sv */
// Types and helpers shared by the cascaded divider
package cdd_pkg;
  typedef enum logic [1:0] {
    CDD_PRE_NONE = 2'b00,
    CDD_PRE_DIV2 = 2'b01,
    CDD_PRE_DIV3 = 2'b10,
    CDD_PRE_DIV5 = 2'b11
  } cdd_pre_t;

  // Period minus one in input cycles
  function automatic logic [4:0] cdd_period_m1(input logic [3:0] n, input logic [3:0] m);
    cdd_period_m1 = {1'b0, n} + {1'b0, m} + 5'h01;
  endfunction

  function automatic logic cdd_is_even(input logic [3:0] n, input logic [3:0] m);
    cdd_is_even = (n[0] == m[0]);
  endfunction

  function automatic logic cdd_is_odd_bal(input logic [3:0] n, input logic [3:0] m);
    cdd_is_odd_bal = ({1'b0, m} == ({1'b0, n} + 5'h01));
  endfunction
endpackage

/* File: rtl/cdd_stage.sv */
// One divider stage working on rise and fall events of its input clock
`timescale 1ns/1ps
`include "cdd_defines.svh"
module cdd_stage import cdd_pkg::*; (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       in_lvl,
  input  wire logic       in_rise,
  input  wire logic       in_fall,
  input  wire logic       bypass,
  input  wire logic       dcc_en,
  input  wire logic [3:0] n,
  input  wire logic [3:0] m,
  output logic            out_lvl,
  output logic            out_rise,
  output logic            out_fall
);
  logic [4:0] cnt;
  logic       next_out;
  logic       dcc_odd;
  logic [4:0] period_m1;

  assign period_m1 = cdd_period_m1(n, m);
  // Half-cycle placement only for an odd stage set up with one extra low cycle
  assign dcc_odd   = dcc_en && cdd_is_odd_bal(n, m); // [R8]

  always_comb begin
    next_out = out_lvl;
    if (bypass) begin
      next_out = in_lvl; // [R6]
    end else if (in_rise && (cnt >= period_m1)) begin
      next_out = 1'b1; // [R13]
    end else if (in_rise && !dcc_odd && (cnt == {1'b0, n})) begin
      next_out = 1'b0; // [R7] [R12]
    end else if (in_fall && dcc_odd && (cnt == ({1'b0, n} + 5'h01))) begin
      next_out = 1'b0; // [R8] [R9] [R10]
    end
  end

  // Starts at the top so the first input rise opens a high phase
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= `CDD_CNT_START;
    end else if (bypass) begin
      cnt <= `CDD_CNT_START;
    end else if (in_rise) begin
      cnt <= (cnt >= period_m1) ? 5'h00 : cnt + 5'h01; // [R12] [R13]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_lvl  <= 1'b0;
      out_rise <= 1'b0;
      out_fall <= 1'b0;
    end else begin
      out_lvl  <= next_out;
      out_rise <= next_out & ~out_lvl;
      out_fall <= ~next_out & out_lvl;
    end
  end

  sequence s_byp_rise;
    in_rise && !out_lvl && bypass;
  endsequence
  sequence s_byp_hold;
    bypass;
  endsequence

  AST_BYPASS_FOLLOW: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R6]
    s_byp_rise ##1 s_byp_hold |-> out_rise && out_lvl)
    else $error("bypassed stage did not follow input rise");

  AST_FALL_COUNT: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R7]
    out_fall && $past(!bypass) && $past(!dcc_odd) && $stable(n) && $past(in_rise)
    |-> cnt == ({1'b0, n} + 5'h01))
    else $error("uncorrected high phase not n plus one cycles");

  AST_DCC_HALF: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R8]
    out_fall && $past(!bypass) && $past(dcc_odd) && $past(!in_rise) |-> $past(in_fall))
    else $error("corrected odd stage fell off an input fall");

  AST_RISE_WRAP: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R13]
    out_rise && $past(!bypass) |-> cnt == 5'h00 && $past(in_rise))
    else $error("stage rose without period wrap");

  AST_EVEN_HALF: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R9]
    out_fall && $past(!bypass) && $past(n == m) && $stable(n) |-> $past(in_rise))
    else $error("balanced even stage fell off an input rise");
endmodule

/* File: rtl/cdd_top.sv */
// Cascaded two-stage channel divider with upstream divider and duty correction
`timescale 1ns/1ps
`include "cdd_defines.svh"
module cdd_top import cdd_pkg::*; (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       src_clk,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rdata,
  output logic            clk_out
);
  logic [7:0] stage1_cfg;
  logic [7:0] stage2_cfg;
  logic [7:0] ctrl;
  logic       src_meta;
  logic       src_sync;
  logic       src_prev;
  logic       src_rise;
  logic       src_fall;
  logic       dcc_en;
  logic       byp1;
  logic       byp2;
  cdd_pre_t   pre_sel;
  logic [3:0] pre_n;
  logic [3:0] pre_m;
  logic [3:0] n1;
  logic [3:0] m1;
  logic [3:0] n2;
  logic [3:0] m2;
  logic       pre_lvl;
  logic       pre_rise;
  logic       pre_fall;
  logic       s1_lvl;
  logic       s1_rise;
  logic       s1_fall;
  logic       s2_rise;
  logic       s2_fall;
  logic [7:0] status;

  // Register writes
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1_cfg <= `CDD_STAGE_RESET;
      stage2_cfg <= `CDD_STAGE_RESET;
      ctrl       <= `CDD_CTRL_RESET; // [R11]
    end else if (wr_en) begin
      if (addr == `CDD_ADDR_STAGE1) begin
        stage1_cfg <= wdata;
      end
      if (addr == `CDD_ADDR_STAGE2) begin
        stage2_cfg <= wdata;
      end
      if (addr == `CDD_ADDR_CTRL) begin
        ctrl <= wdata;
      end
    end
  end

  assign dcc_en  = ~ctrl[`CDD_CTRL_DCC_DIS]; // [R11]
  assign byp1    = ctrl[`CDD_CTRL_BYP1];
  assign byp2    = ctrl[`CDD_CTRL_BYP2];
  assign pre_sel = cdd_pre_t'(ctrl[`CDD_CTRL_PRE_MSB:`CDD_CTRL_PRE_LSB]);
  assign n1      = stage1_cfg[`CDD_HIGH_MSB:`CDD_HIGH_LSB];
  assign m1      = stage1_cfg[`CDD_LOW_MSB:`CDD_LOW_LSB];
  assign n2      = stage2_cfg[`CDD_HIGH_MSB:`CDD_HIGH_LSB];
  assign m2      = stage2_cfg[`CDD_LOW_MSB:`CDD_LOW_LSB];

  // Upstream ratio as high and low counts: 2 = 1+1, 3 = 1+2, 5 = 2+3
  always_comb begin
    unique case (pre_sel)
      CDD_PRE_NONE: begin
        pre_n = `CDD_PRE2_HIGH;
        pre_m = `CDD_PRE2_LOW;
      end
      CDD_PRE_DIV2: begin
        pre_n = `CDD_PRE2_HIGH;
        pre_m = `CDD_PRE2_LOW;
      end
      CDD_PRE_DIV3: begin
        pre_n = `CDD_PRE3_HIGH; // [R5] [R10]
        pre_m = `CDD_PRE3_LOW;
      end
      CDD_PRE_DIV5: begin
        pre_n = `CDD_PRE5_HIGH; // [R5] [R10]
        pre_m = `CDD_PRE5_LOW;
      end
    endcase
  end

  // Source pin synchroniser; edges only seen after the second flop
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      src_meta <= 1'b0;
      src_sync <= 1'b0;
      src_prev <= 1'b0;
    end else begin
      src_meta <= src_clk;
      src_sync <= src_meta;
      src_prev <= src_sync;
    end
  end

  // Source must stay well below half of ref_clk for both edges to be seen
  assign src_rise = src_sync & ~src_prev;
  assign src_fall = ~src_sync & src_prev;

  cdd_stage u_pre (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .in_lvl   (src_sync),
    .in_rise  (src_rise),
    .in_fall  (src_fall),
    .bypass   (pre_sel == CDD_PRE_NONE),
    .dcc_en   (dcc_en),
    .n        (pre_n),
    .m        (pre_m),
    .out_lvl  (pre_lvl),
    .out_rise (pre_rise),
    .out_fall (pre_fall)
  );

  cdd_stage u_stage1 (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .in_lvl   (pre_lvl),
    .in_rise  (pre_rise),
    .in_fall  (pre_fall),
    .bypass   (byp1),
    .dcc_en   (dcc_en),
    .n        (n1),
    .m        (m1),
    .out_lvl  (s1_lvl),
    .out_rise (s1_rise),
    .out_fall (s1_fall)
  );

  // Second stage counts first-stage edges, giving the product ratio
  cdd_stage u_stage2 (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .in_lvl   (s1_lvl),
    .in_rise  (s1_rise), // [R13]
    .in_fall  (s1_fall),
    .bypass   (byp2),
    .dcc_en   (dcc_en),
    .n        (n2),
    .m        (m2),
    .out_lvl  (clk_out),
    .out_rise (s2_rise),
    .out_fall (s2_fall)
  );

  // Status flags software misuse of the counts and bypass bits; hardware still divides
  always_comb begin
    status                     = 8'h00;
    status[`CDD_STAT_CLK]      = clk_out;
    status[`CDD_STAT_BYP_MIS]  = byp1 & ~byp2; // [R3]
    status[`CDD_STAT_UNBAL]    = dcc_en & ((~byp1 & (n1 != m1) & ~cdd_is_odd_bal(n1, m1))
                               | (~byp2 & (n2 != m2) & ~cdd_is_odd_bal(n2, m2))); // [R1] [R2]
    status[`CDD_STAT_EVEN_MIS] = ~byp1 & ~byp2 & cdd_is_even(n1, m1)
                               & ~cdd_is_even(n2, m2); // [R4]
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 8'h00;
    end else if (rd_en) begin
      unique case (addr)
        `CDD_ADDR_STAGE1: rdata <= stage1_cfg;
        `CDD_ADDR_STAGE2: rdata <= stage2_cfg;
        `CDD_ADDR_CTRL:   rdata <= ctrl;
        `CDD_ADDR_STATUS: rdata <= status;
        default:          rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  AST_DCC_DEFAULT: assert property (@(posedge ref_clk) // [R11]
    $rose(rst_b) |-> dcc_en)
    else $error("correction not enabled after reset");

  AST_BOTH_BYPASS: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R6]
    byp1 && byp2 && $past(byp1 && byp2, 2) && $past(byp1 && byp2)
    |-> clk_out == $past(pre_lvl, 2))
    else $error("bypassed stages changed the clock");

  AST_STAGE2_PULSES: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R7]
    !(s2_rise && s2_fall) && (!s2_rise || clk_out) && (!s2_fall || !clk_out))
    else $error("output edge pulse disagrees with level");
endmodule

/* File: tb/cdd_src_model.sv */
// Behavioural divider input clock source feeding the stages
`timescale 1ns/1ps
module cdd_src_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] hi_len,
  input  wire logic [7:0] lo_len,
  output logic            src_clk
);
  logic [7:0] cnt;

  // Levels counted in whole ref_clk cycles; lengths of 2 or more keep the sync happy
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt     <= 8'h00;
      src_clk <= 1'b0;
    end else if (cnt + 8'h01 >= (src_clk ? hi_len : lo_len)) begin
      cnt     <= 8'h00;
      src_clk <= ~src_clk;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule

/* File: tb/tb_cdd_top.sv */
// Register and duty cycle tests of the cascaded divider
`timescale 1ns/1ps
module tb_cdd_top;
  logic       ref_clk;
  logic       rst_b;
  logic       src_clk;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] rdata;
  logic       clk_out;
  logic [7:0] hi_len;
  logic [7:0] lo_len;
  logic [7:0] d;
  logic [15:0] h;
  logic [15:0] l;
  int         err_count;
  int         total_checks;

  cdd_src_model i_cdd_src_model (
    .ref_clk(ref_clk), .rst_b(rst_b), .hi_len(hi_len), .lo_len(lo_len), .src_clk(src_clk)
  );
  cdd_top i_cdd_top (
    .ref_clk(ref_clk), .rst_b(rst_b), .src_clk(src_clk), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .clk_out(clk_out)
  );

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(negedge ref_clk);
    v = rdata;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkdur(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Fifth period from the first rise kept, the second and fourth skipped; the first after a change may be irregular
  task automatic meas(output logic [15:0] hc, output logic [15:0] lc);
    int i;
    i = 0;
    hc = 16'h0000;
    lc = 16'h0000;
    repeat (3) begin
      while (clk_out !== 1'b0 && i < 3000) begin
        @(negedge ref_clk);
        i++;
      end
      while (clk_out !== 1'b1 && i < 3000) begin
        @(negedge ref_clk);
        i++;
      end
      hc = 16'h0000;
      lc = 16'h0000;
      while (clk_out === 1'b1 && hc < 16'h0800) begin
        @(negedge ref_clk);
        hc++;
      end
      while (clk_out === 1'b0 && lc < 16'h0800) begin
        @(negedge ref_clk);
        lc++;
      end
    end
  endtask

  task automatic run(input int n, input logic [7:0] ctrl, input logic [7:0] s1,
                     input logic [7:0] s2, input logic [7:0] sh, input logic [7:0] sl,
                     input logic [15:0] eh, input logic [15:0] el);
    wr(4'h0, s1);
    wr(4'h1, s2);
    wr(4'h2, ctrl);
    @(posedge ref_clk);
    hi_len <= sh;
    lo_len <= sl;
    meas(h, l);
    chkdur(h, eh);
    chkdur(l, el);
    $display("test %0d done", n);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    #5_000_000;
    err_count++;
    end_of_test();
  end

  initial begin
    err_count = 0;
    total_checks = 0;
    rst_b  = 1'b0;
    addr   = 4'h0;
    wdata  = 8'h00;
    wr_en  = 1'b0;
    rd_en  = 1'b0;
    hi_len = 8'h02;
    lo_len = 8'h02;
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(4'h2, d); chk8(d, 8'h30);
    rd(4'h0, d); chk8(d, 8'h00);
    rd(4'h4, d); chk8(d, 8'h00);
    $display("test 0 done");
    // Stage counts follow the balance and placement
    run(1, 8'h31, 8'h00, 8'h00, 8'h03, 8'h05, 16'd3, 16'd5);
    run(2, 8'h71, 8'h00, 8'h00, 8'h03, 8'h05, 16'd8, 16'd8);
    run(3, 8'hb1, 8'h00, 8'h00, 8'h02, 8'h02, 16'd4, 16'd8);
    run(4, 8'hf1, 8'h00, 8'h00, 8'h02, 8'h02, 16'd8, 16'd12);
    run(5, 8'h21, 8'h21, 8'h00, 8'h02, 8'h02, 16'd8, 16'd12);
    run(6, 8'h01, 8'h21, 8'h10, 8'h02, 8'h02, 16'd20, 16'd40);
    run(7, 8'h20, 8'h11, 8'h00, 8'h03, 8'h05, 16'd16, 16'd16);
    run(8, 8'h70, 8'h00, 8'h00, 8'h03, 8'h05, 16'd8, 16'd8);
    run(9, 8'h20, 8'h10, 8'h00, 8'h02, 8'h02, 16'd6, 16'd6);
    run(10, 8'hb0, 8'h00, 8'h00, 8'h03, 8'h05, 16'd11, 16'd13);
    run(11, 8'hf0, 8'h00, 8'h00, 8'h03, 8'h05, 16'd19, 16'd21);
    run(12, 8'h00, 8'h10, 8'h10, 8'h02, 8'h02, 16'd18, 16'd18);
    // Misplaced bypass and unbalanced stage are only flagged, not blocked
    wr(4'h1, 8'h30);
    wr(4'h2, 8'h10);
    rd(4'h3, d); chk8(d & 8'h0e, 8'h06);
    rd(4'h1, d); chk8(d, 8'h30);
    // Even first stage ahead of an odd second one is flagged
    wr(4'h0, 8'h11);
    wr(4'h1, 8'h10);
    wr(4'h2, 8'h00);
    rd(4'h3, d); chk8(d & 8'h0e, 8'h08);
    $display("test 13 done");
    end_of_test();
  end
endmodule
